// [inc/fsc_regs.vh]
// Constants for the flash status-read controller
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
// ==========================================
// APB register offsets
`define FSC_OFF_CTRL 12'h000
`define FSC_OFF_CMD 12'h004
`define FSC_OFF_STAT 12'h008
`define FSC_OFF_RESULT 12'h00C
// ==========================================
// Control register fields
`define FSC_CTRL_GO 0
`define FSC_CTRL_CLEAR 1
`define FSC_CTRL_POLL 2
// Controller status register fields
`define FSC_STAT_BUSY 0
`define FSC_STAT_DONE 1
`define FSC_STAT_VALID 2
`define FSC_STAT_READY 3
// ==========================================
// Device status word bit positions
`define FSC_BIT_READY 7
`define FSC_BIT_ESUSP 6
`define FSC_BIT_EFAIL 5
`define FSC_BIT_PFAIL 4
`define FSC_BIT_ABORT 3
`define FSC_BIT_PSUSP 2
`define FSC_BIT_LOCK 1
`define FSC_BIT_CONT 0
// Meaningful bits 7..1 of the status word
`define FSC_STATUS_MASK 16'h0000_00FE
// ==========================================
// Reset values
`define FSC_RST_CMD 32'h0000_0000
// ==========================================
// Bus timing in ns and derived cycle counts at 100 ns
`define FSC_CLK_NS 100
`define FSC_PULSE_NS 100
`define FSC_RECOV_NS 35
// Extra read cycles spent in the data synchroniser
`define FSC_SYNC_CYC 4
`define FSC_PULSE_CYC ((`FSC_PULSE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_RECOV_CYC ((`FSC_RECOV_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`endif

// [rtl/fsc_sync.v]
// Three-stage synchroniser for the flash data bus
`timescale 1ns/10ps
module fsc_sync #(
  parameter W = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  // ==========================================
  // Sync chain; output updates once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // fsc_sync

// [rtl/fsc_ctrl.v]
// Host controller that reads the flash status word over the parallel bus
// How it works
// - Hold select high for recovery after read
// - Host ignores upper byte bits 15..8
// - Host masks continuity bit 0
// - Bits 6..1 valid only when ready
// - After suspend, poll until ready
`timescale 1ns/10ps
`include "fsc_regs.vh"
module fsc_ctrl #(
  parameter AW = 23,
  parameter DW = 16,
  parameter [DW-1:0] STATUS_READ_DATA = 16'h0070,
  parameter [DW-1:0] CLEAR_DATA = 16'h0071,
  parameter [AW-1:0] CMD_ADDR = 23'h00_0555
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Flash parallel bus
  output reg [AW-1:0] flash_addr,
  output reg flash_select_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  input wire [DW-1:0] flash_dq_in,
  output reg [DW-1:0] flash_dq_out,
  output reg flash_dq_oe
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WR = 3'd1;
  localparam [2:0] ST_RECW = 3'd2;
  localparam [2:0] ST_RD = 3'd3;
  localparam [2:0] ST_CAP = 3'd4;
  localparam [2:0] ST_RECR = 3'd5;
  // Counts are integers; cut to the counter width on purpose
  localparam [31:0] PULSE_W = `FSC_PULSE_CYC;
  localparam [31:0] RECOV_W = `FSC_RECOV_CYC;
  localparam [31:0] SYNC_W = `FSC_SYNC_CYC;
  localparam [7:0] PULSE = PULSE_W[7:0];
  localparam [7:0] RECOV = RECOV_W[7:0];
  localparam [7:0] SYNC = SYNC_W[7:0];

  reg [2:0] state;
  reg [7:0] cnt;
  reg is_clear;
  reg poll;
  reg done;
  reg valid;
  reg [DW-1:0] status;
  reg [31:0] ctrl_cmd;
  wire [DW-1:0] dq_sync;
  wire wr_acc;
  wire rd_acc;
  wire busy;

  // ==========================================
  // Input synchroniser for read data
  fsc_sync #(.W(DW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(flash_dq_in),
    .dout(dq_sync)
  );

  // Masked view: keep bits 7..1 only
  function [DW-1:0] fsc_mask;
    input [DW-1:0] w;
    begin
      fsc_mask = w & `FSC_STATUS_MASK;
    end
  endfunction

  // ==========================================
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign busy = (state != ST_IDLE);

  // Read mux
  always @* begin
    case (paddr)
      `FSC_OFF_CTRL: prdata = {29'd0, poll, 2'b00};
      `FSC_OFF_CMD: prdata = ctrl_cmd;
      `FSC_OFF_STAT: prdata = {28'd0,
        status[`FSC_BIT_READY], valid, done, busy};
      `FSC_OFF_RESULT: prdata = {16'd0, fsc_mask(status)};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // Sequencer: command write, recovery; for a status read also one read, recovery
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= 8'd0;
      is_clear <= 1'b0;
      poll <= 1'b0;
      done <= 1'b0;
      valid <= 1'b0;
      status <= {DW{1'b0}};
      ctrl_cmd <= `FSC_RST_CMD;
      flash_addr <= {AW{1'b0}};
      flash_select_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= {DW{1'b0}};
      flash_dq_oe <= 1'b0;
    end else begin
      if (wr_acc && paddr == `FSC_OFF_CMD) begin
        ctrl_cmd <= pwdata;
      end
      if (wr_acc && paddr == `FSC_OFF_CTRL) begin
        poll <= pwdata[`FSC_CTRL_POLL];
      end
      case (state)
        ST_IDLE: begin
          if (wr_acc && paddr == `FSC_OFF_CTRL &&
              (pwdata[`FSC_CTRL_GO] || pwdata[`FSC_CTRL_CLEAR])) begin
            // Issue command as a bus write cycle
            is_clear <= pwdata[`FSC_CTRL_CLEAR];
            done <= 1'b0;
            flash_addr <= CMD_ADDR;
            flash_dq_out <= pwdata[`FSC_CTRL_CLEAR] ? CLEAR_DATA
                                                    : STATUS_READ_DATA;
            flash_dq_oe <= 1'b1;
            flash_select_n <= 1'b0;
            flash_we_n <= 1'b0;
            cnt <= PULSE;
            state <= ST_WR;
          end
        end
        ST_WR: begin
          if (cnt > 8'd1) begin
            cnt <= cnt - 8'd1;
          end else begin
            flash_we_n <= 1'b1;
            flash_select_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            cnt <= RECOV;
            state <= ST_RECW;
          end
        end
        ST_RECW: begin
          if (cnt > 8'd1) begin
            cnt <= cnt - 8'd1;
          end else if (is_clear) begin
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            // Single overlay read at any address
            flash_select_n <= 1'b0;
            flash_oe_n <= 1'b0;
            cnt <= PULSE + SYNC;
            state <= ST_RD;
          end
        end
        ST_RD: begin
          if (cnt > 8'd1) begin
            cnt <= cnt - 8'd1;
          end else begin
            state <= ST_CAP;
          end
        end
        ST_CAP: begin
          // Capture the 16-bit word then end the read
          status <= dq_sync;
          valid <= dq_sync[`FSC_BIT_READY];
          flash_oe_n <= 1'b1;
          flash_select_n <= 1'b1;
          cnt <= RECOV;
          state <= ST_RECR;
        end
        ST_RECR: begin
          // Hold select and enable high for recovery
          if (cnt > 8'd1) begin
            cnt <= cnt - 8'd1;
          end else if (poll && !status[`FSC_BIT_READY]) begin
            // Keep polling until the device is ready
            flash_addr <= CMD_ADDR;
            flash_dq_out <= STATUS_READ_DATA;
            flash_dq_oe <= 1'b1;
            flash_select_n <= 1'b0;
            flash_we_n <= 1'b0;
            cnt <= PULSE;
            state <= ST_WR;
          end else begin
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fsc_ctrl

// [verif/fsc_ctrl_sva.sv]
// Assertion checker for the flash status-read controller
`timescale 1ns/10ps
module fsc_ctrl_sva (
  // Clock, reset and APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  // Flash side
  input wire [22:0] flash_addr,
  input wire flash_select_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire flash_dq_oe,
  input wire [15:0] flash_dq_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // Strobe sequencing
  a_we_one: assert property ($fell(flash_we_n) |=> flash_we_n)
    else $error("write strobe too long");
  a_cmd_drive: assert property (
    !flash_we_n |-> flash_dq_oe && flash_oe_n)
    else $error("command not driven");
  a_strobe_select: assert property (
    !flash_oe_n || !flash_we_n |-> !flash_select_n)
    else $error("strobe without select");
  a_read_hiz: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("bus driven in read");
  a_addr_hold: assert property (!flash_oe_n |-> $stable(flash_addr))
    else $error("address moved in read");
  a_read_len: assert property ($fell(flash_oe_n) |->
    (!flash_oe_n)[*6] ##1 flash_oe_n) else $error("read length wrong");
  a_recover_high: assert property (
    $rose(flash_oe_n) |-> flash_oe_n[*2]) else $error("recovery too short");
  a_status_then_read: assert property ($rose(flash_we_n) &&
    $past(flash_dq_out) == 16'h0070 |=> !flash_oe_n) else $error("no read");
  a_clear_no_read: assert property ($rose(flash_we_n) &&
    $past(flash_dq_out) == 16'h0071 |-> flash_oe_n[*3]) else $error("read");
  a_result_mask: assert property (
    psel && !pwrite && paddr == 12'h00C |->
    (prdata & 32'hFFFF_FF01) == 32'h0000_0000) else $error("mask");
  // Main scenarios
  c_read: cover property ($fell(flash_oe_n));
  c_clear: cover property ($rose(flash_we_n) && flash_dq_out == 16'h0071);
  c_result: cover property (psel && !pwrite && paddr == 12'h00C);
endmodule // fsc_ctrl_sva
bind fsc_ctrl fsc_ctrl_sva fsc_ctrl_sva_i (.pclk, .presetn, .psel, .pwrite,
  .paddr, .prdata, .flash_addr, .flash_select_n, .flash_oe_n, .flash_we_n,
  .flash_dq_oe, .flash_dq_out);

// [verif/fsc_flash_model.sv]
// Behavioural flash device holding the status word
`timescale 1ns/10ps
module fsc_flash_model (
  // Parallel bus
  input wire flash_select_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire [15:0] flash_dq_out,
  output reg [15:0] flash_dq_in,
  // Bench event hook
  input wire load_en,
  input wire [7:0] load_val
);
  reg [7:0] st = 8'h80;
  reg ovl = 1'b0;
  initial flash_dq_in = 16'h0F0F;
  // Command decode at end of write strobe
  always @(posedge flash_we_n) begin
    if (flash_dq_out == 16'h0070) ovl = 1'b1;
    if (flash_dq_out == 16'h0071) st = st & 8'hC4;
  end
  // Overlay ends after one read
  always @(posedge flash_oe_n) ovl = 1'b0;
  // New operation outcome, suspend and resume state
  always @(posedge load_en) st = load_val;
  // Read data; released bus keeps changing
  always @(flash_oe_n or flash_select_n or ovl or st) begin
    if (!flash_oe_n && !flash_select_n)
      flash_dq_in = ovl ? {~flash_dq_in[15:8], st} : 16'h5A5A;
    else
      flash_dq_in = ~flash_dq_in;
  end
endmodule // fsc_flash_model

// [verif/testbench.sv]
// Self-checking bench for the flash status-read controller
`timescale 1ns/10ps
`include "fsc_regs.vh"
module testbench;
  localparam [63:0] PATS = 64'h80A0_9088_82C0_8481;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, load_en = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000, rd;
  reg [7:0] load_val = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, flash_select_n, flash_oe_n, flash_we_n, flash_dq_oe;
  wire [22:0] flash_addr;
  wire [15:0] flash_dq_in, flash_dq_out;
  integer fail_count = 0, total_checks = 0, i;
  initial forever #50 pclk = ~pclk;
  fsc_ctrl fsc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_select_n,
    .flash_oe_n, .flash_we_n, .flash_dq_in, .flash_dq_out, .flash_dq_oe);
  fsc_flash_model fsc_flash_model_i (.flash_select_n, .flash_oe_n,
    .flash_we_n, .flash_dq_out, .flash_dq_in, .load_en, .load_val);
  // ====================
  // Checking and closing
  task chk(input string nm, input [31:0] s, input [31:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("mismatch %0s exp %h seen %h", nm, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // APB transfer, bounded wait on pready
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    if (n == 20) begin
      fail_count = fail_count + 1;
      final_report;
    end
  endtask
  // Poll controller status until done
  task wait_done;
    integer k;
    k = 0;
    rd = 32'h0000_0000;
    while (rd[`FSC_STAT_DONE] !== 1'b1 && k < 60) begin
      apb(1'b0, `FSC_OFF_STAT, 32'h0000_0000);
      k = k + 1;
    end
    if (k == 60) begin
      fail_count = fail_count + 1;
      final_report;
    end
  endtask
  task ld(input [7:0] v);
    @(posedge pclk);
    load_val <= v; load_en <= 1'b1;
    @(posedge pclk);
    load_en <= 1'b0;
  endtask
  task go(input [31:0] c);
    apb(1'b1, `FSC_OFF_CTRL, c);
    wait_done;
    apb(1'b0, `FSC_OFF_RESULT, 32'h0000_0000);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    chk("slverr", {31'd0, pslverr}, 32'h0000_0000);
    apb(1'b1, `FSC_OFF_CMD, 32'h1234_5678);
    apb(1'b0, `FSC_OFF_CMD, 32'h0000_0000);
    chk("scratch", rd, 32'h1234_5678);
    go(32'h0000_0001);
    chk("reset word", rd, 32'h0000_0080);
    for (i = 0; i < 8; i = i + 1) begin
      ld(PATS[8*i +: 8]);
      go(32'h0000_0001);
      chk("flags", rd, {24'h00_0000, PATS[8*i +: 8] & 8'hFE});
      chk("overlay", {31'd0, fsc_flash_model_i.ovl}, 32'h0000_0000);
    end
    ld(8'hFF);
    go(32'h0000_0002);
    go(32'h0000_0001);
    chk("cleared", rd, 32'h0000_00C4);
    ld(8'h00);
    apb(1'b1, `FSC_OFF_CTRL, 32'h0000_0005);
    apb(1'b0, `FSC_OFF_CTRL, 32'h0000_0000);
    chk("poll bit", rd, 32'h0000_0004);
    apb(1'b0, `FSC_OFF_STAT, 32'h0000_0000);
    chk("busy", {31'd0, rd[`FSC_STAT_BUSY]}, 32'h0000_0001);
    repeat (30) @(posedge pclk);
    ld(8'hA8);
    wait_done;
    chk("valid", {31'd0, rd[`FSC_STAT_VALID]}, 32'h0000_0001);
    chk("ready", {31'd0, rd[`FSC_STAT_READY]}, 32'h0000_0001);
    apb(1'b0, `FSC_OFF_RESULT, 32'h0000_0000);
    chk("poll", rd, 32'h0000_00A8);
    // Reset in the middle of a read; controller must start clean
    apb(1'b1, `FSC_OFF_CTRL, 32'h0000_0005);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FSC_OFF_STAT, 32'h0000_0000);
    chk("stat after reset", rd, 32'h0000_0000);
    apb(1'b0, `FSC_OFF_CTRL, 32'h0000_0000);
    chk("ctrl after reset", rd, 32'h0000_0000);
    apb(1'b0, `FSC_OFF_CMD, 32'h0000_0000);
    chk("cmd after reset", rd, `FSC_RST_CMD);
    go(32'h0000_0001);
    chk("read after reset", rd, 32'h0000_00A8);
    final_report;
  end
endmodule // testbench
